/* File: inc/vfc_pkg.sv */
// Shared constants, types and register map of the vector float-to-integer converter.
package vfc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_SRC_UP   = 8'h00; // Upper lane of the source operand.
  localparam logic [7:0]  OFS_SRC_LO   = 8'h04; // Lower lane of the source operand.
  localparam logic [7:0]  OFS_CTRL     = 8'h08; // Mode, rounding and exception enables.
  localparam logic [7:0]  OFS_CMD      = 8'h0c; // Write bit 0 to start a conversion.
  localparam logic [7:0]  OFS_DST_UP   = 8'h10; // Upper lane of the destination.
  localparam logic [7:0]  OFS_DST_LO   = 8'h14; // Lower lane of the destination.
  localparam logic [7:0]  OFS_STATUS   = 8'h18; // Status flags and busy bit.

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB  = 0; // Two bits of conversion mode.
  localparam int unsigned CTRL_RND_LSB   = 2; // Two bits of rounding mode.
  localparam int unsigned CTRL_INVE_BIT  = 4; // Invalid exception enable.
  localparam int unsigned CTRL_INXE_BIT  = 5; // Inexact exception enable.
  localparam int unsigned CMD_START_BIT  = 0; // Start strobe in the command word.
  localparam int unsigned STAT_SUMM_BIT  = 6; // Sticky inexact summary, write one to clear.
  localparam int unsigned STAT_BUSY_BIT  = 7; // Conversion in flight.

  // ---------------------------------------------------------------------------
  // Float format limits and saturation values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  EXP_MAX        = 8'hff; // Infinity and not-a-number.
  localparam logic [7:0]  EXP_SI_LIMIT   = 8'h9e; // 158: first exponent out of signed range.
  localparam logic [7:0]  EXP_UF_LIMIT   = 8'h7f; // 127: first exponent out of fraction range.
  localparam logic [8:0]  FRAC_OFFSET    = 9'h020; // Fraction mode scales by two to the 32.
  localparam logic [8:0]  INT_POINT      = 9'h096; // 150: exponent whose value is the mantissa.
  localparam logic [8:0]  SHIFT_LOST     = 9'h058; // 88: right shift that loses every bit.
  localparam logic [31:0] SAT_POS        = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG        = 32'h80000000;
  localparam logic [31:0] SAT_UNS        = 32'hffffffff;
  localparam logic [31:0] WORD_RESET     = 32'h00000000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VFC_MODE_SI_TRUNC,
    VFC_MODE_UFRAC,
    VFC_MODE_UINT,
    VFC_MODE_UINT_TRUNC
  } vfc_mode_t;

  typedef enum logic [1:0] {
    VFC_RND_NEAREST,
    VFC_RND_ZERO,
    VFC_RND_UP,
    VFC_RND_DOWN
  } vfc_round_t;

  // Answer of one lane converter.
  typedef struct packed {
    logic [31:0] value;       // Result under the selected rounding.
    logic [31:0] trunc_value; // Result truncated toward zero.
    logic        invalid;     // Special input or overflow.
    logic        guard;       // First bit below the result.
    logic        sticky;      // Or of all further bits.
  } vfc_lane_t;

  // Status word; low_invalid sits in bit 0.
  typedef struct packed {
    logic inexact_sticky_summary;
    logic high_sticky_flag;
    logic high_guard_flag;
    logic low_sticky_flag;
    logic low_guard_flag;
    logic high_invalid_flag;
    logic low_invalid_flag;
  } vfc_status_t;

endpackage

/* File: logic/vfc_conv.sv */
// Top of the two-lane float-to-integer converter with its APB register file.
//
// Functional notes
// - Signed mode truncates toward zero, saturates.
// - Signed mode turns denormals into zero.
// - Signed exponent below 158 converts normally.
// - Negative exponent-158 zero-fraction gives minimum, valid.
// - Not-a-number converts as zero.
// - Signed overflow saturates by sign.
// - Unsigned modes give zero for negatives, zeros.
// - Unrepresentable fraction saturates to all ones.
// - Unsigned integer saturates above exponent 158.
// - Rounding unsigned integer mode uses selected rounding.
// - Specials or overflow flag invalid, clear guard/sticky.
// - Enabled invalid exception keeps destination, sets only invalid flags.
// - Inexact without exception sets sticky summary.
// - Enabled inexact exception writes truncated result.
// - Guard and sticky recorded per lane.
//
// The APB slave port and the address map were left to the implementer.
module vfc_conv (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             exc_invalid,
  output logic             exc_round,
  output logic             conv_done
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------

  // Everything the block remembers, held in one register.
  typedef struct packed {
    logic [31:0]          src_up;      // Upper lane of the source operand.
    logic [31:0]          src_lo;      // Lower lane of the source operand.
    logic [31:0]          dst_up;      // Upper lane of the destination.
    logic [31:0]          dst_lo;      // Lower lane of the destination.
    vfc_pkg::vfc_mode_t   mode;        // Conversion mode of the next operation.
    vfc_pkg::vfc_round_t  rnd;         // Current rounding mode.
    logic                 inv_en;      // Invalid exception enable.
    logic                 inx_en;      // Inexact exception enable.
    vfc_pkg::vfc_status_t status;      // Status flags.
    logic                 go;          // Conversion waiting to commit.
    logic                 exc_invalid; // Invalid exception pulse.
    logic                 exc_round;   // Round exception pulse.
    logic                 done;        // Completion pulse.
    logic [31:0]          rdata;       // Read data for the current access.
  } vfc_state_t;

  vfc_state_t         state_reg;  // Registered state.
  vfc_state_t         state_next; // Next value of the state.
  vfc_pkg::vfc_lane_t lane_up;    // Answer of the upper lane.
  vfc_pkg::vfc_lane_t lane_lo;    // Answer of the lower lane.
  logic               mapped;     // Address hits a register.

  // ---------------------------------------------------------------------------
  // Lane converters
  // ---------------------------------------------------------------------------

  // Both lanes see the same mode and rounding in the same operation.
  vfc_lane u_lane_up (
    .operand (state_reg.src_up),
    .mode    (state_reg.mode),
    .rnd     (state_reg.rnd),
    .res     (lane_up)
  );

  // The lower lane runs in parallel with the upper one.
  vfc_lane u_lane_lo (
    .operand (state_reg.src_lo),
    .mode    (state_reg.mode),
    .rnd     (state_reg.rnd),
    .res     (lane_lo)
  );

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------

  // Flags any address that names a register.
  always_comb begin
    case (paddr)
      vfc_pkg::OFS_SRC_UP,
      vfc_pkg::OFS_SRC_LO,
      vfc_pkg::OFS_CTRL,
      vfc_pkg::OFS_CMD,
      vfc_pkg::OFS_DST_UP,
      vfc_pkg::OFS_DST_LO,
      vfc_pkg::OFS_STATUS: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // The slave never inserts wait states.
  assign pready = 1'b1;

  // An unmapped address answers with an error in the access phase.
  assign pslverr = psel & penable & ~mapped;

  // Outputs come straight from the state register.
  assign prdata      = state_reg.rdata;
  assign exc_invalid = state_reg.exc_invalid;
  assign exc_round   = state_reg.exc_round;
  assign conv_done   = state_reg.done;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------

  // Serves the bus, starts conversions and commits their results.
  always_comb begin
    logic any_invalid;
    logic any_inexact;
    logic setup;
    logic wr;
    any_invalid = lane_up.invalid | lane_lo.invalid;
    any_inexact = lane_up.guard | lane_up.sticky | lane_lo.guard | lane_lo.sticky;
    setup       = psel & ~penable;
    wr          = psel & penable & pwrite & mapped;
    state_next  = state_reg;
    // Pulses last a single cycle.
    state_next.exc_invalid = 1'b0;
    state_next.exc_round   = 1'b0;
    state_next.done        = 1'b0;

    // Read data is captured in the setup phase so it is ready for access.
    if (setup) begin
      case (paddr)
        vfc_pkg::OFS_SRC_UP: state_next.rdata = state_reg.src_up;
        vfc_pkg::OFS_SRC_LO: state_next.rdata = state_reg.src_lo;
        vfc_pkg::OFS_CTRL: begin
          state_next.rdata = vfc_pkg::WORD_RESET;
          state_next.rdata[vfc_pkg::CTRL_MODE_LSB +: 2] = state_reg.mode;
          state_next.rdata[vfc_pkg::CTRL_RND_LSB +: 2]  = state_reg.rnd;
          state_next.rdata[vfc_pkg::CTRL_INVE_BIT]      = state_reg.inv_en;
          state_next.rdata[vfc_pkg::CTRL_INXE_BIT]      = state_reg.inx_en;
        end
        vfc_pkg::OFS_DST_UP: state_next.rdata = state_reg.dst_up;
        vfc_pkg::OFS_DST_LO: state_next.rdata = state_reg.dst_lo;
        vfc_pkg::OFS_STATUS: begin
          state_next.rdata = vfc_pkg::WORD_RESET;
          state_next.rdata[vfc_pkg::STAT_SUMM_BIT:0]  = state_reg.status;
          state_next.rdata[vfc_pkg::STAT_BUSY_BIT]    = state_reg.go;
        end
        default: state_next.rdata = vfc_pkg::WORD_RESET;
      endcase
    end

    // Writes take effect at the access edge; read-only words ignore them.
    if (wr) begin
      case (paddr)
        vfc_pkg::OFS_SRC_UP: state_next.src_up = pwdata;
        vfc_pkg::OFS_SRC_LO: state_next.src_lo = pwdata;
        vfc_pkg::OFS_CTRL: begin
          state_next.mode   = vfc_pkg::vfc_mode_t'(pwdata[vfc_pkg::CTRL_MODE_LSB +: 2]);
          state_next.rnd    = vfc_pkg::vfc_round_t'(pwdata[vfc_pkg::CTRL_RND_LSB +: 2]);
          state_next.inv_en = pwdata[vfc_pkg::CTRL_INVE_BIT];
          state_next.inx_en = pwdata[vfc_pkg::CTRL_INXE_BIT];
        end
        vfc_pkg::OFS_CMD: begin
          // A start while one is pending is dropped.
          if (pwdata[vfc_pkg::CMD_START_BIT]) begin
            state_next.go = 1'b1;
          end
        end
        vfc_pkg::OFS_STATUS: begin
          // Writing one clears the sticky summary.
          if (pwdata[vfc_pkg::STAT_SUMM_BIT]) begin
            state_next.status.inexact_sticky_summary = 1'b0;
          end
        end
        default: begin
          // Nothing to store.
        end
      endcase
    end

    // Commit one cycle after the start; this sits after the write so a set
    // of the summary in the same cycle as its clear wins.
    if (state_reg.go) begin
      state_next.go   = 1'b0;
      state_next.done = 1'b1;
      // Invalid flags follow each lane on every operation.
      state_next.status.low_invalid_flag  = lane_lo.invalid;
      state_next.status.high_invalid_flag = lane_up.invalid;
      if (any_invalid && state_reg.inv_en) begin
        // Exception taken: destination kept, no other flag set.
        state_next.exc_invalid            = 1'b1;
        state_next.status.low_guard_flag  = 1'b0;
        state_next.status.low_sticky_flag = 1'b0;
        state_next.status.high_guard_flag  = 1'b0;
        state_next.status.high_sticky_flag = 1'b0;
      end else begin
        // Guard and sticky per lane; lanes that are invalid report zero.
        state_next.status.low_guard_flag   = lane_lo.guard;
        state_next.status.low_sticky_flag  = lane_lo.sticky;
        state_next.status.high_guard_flag  = lane_up.guard;
        state_next.status.high_sticky_flag = lane_up.sticky;
        if (any_inexact) begin
          state_next.status.inexact_sticky_summary = 1'b1;
        end
        if (any_inexact && state_reg.inx_en) begin
          // Round exception: the handler finishes the rounding itself.
          state_next.exc_round = 1'b1;
          state_next.dst_up    = lane_up.trunc_value;
          state_next.dst_lo    = lane_lo.trunc_value;
        end else begin
          state_next.dst_up = lane_up.value;
          state_next.dst_lo = lane_lo.value;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Registers the state; reset clears every field.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

/* File: logic/vfc_lane.sv */
// One lane of the float-to-integer converter, purely combinational.
module vfc_lane (
  input  wire logic [31:0]       operand,
  input  vfc_pkg::vfc_mode_t     mode,
  input  vfc_pkg::vfc_round_t    rnd,
  output vfc_pkg::vfc_lane_t     res
);

  // ---------------------------------------------------------------------------
  // Conversion
  // ---------------------------------------------------------------------------

  // Classifies the input, aligns the mantissa and picks the result by mode.
  always_comb begin
    logic        sgn;
    logic [7:0]  expo;
    logic [22:0] frac;
    logic        is_zero;
    logic        is_denorm;
    logic        is_nan;
    logic        is_inf;
    logic        frac_mode;
    logic        trunc_mode;
    logic        in_range;
    logic [8:0]  eff;
    logic [8:0]  rsh;
    logic [87:0] wide;
    logic [31:0] ip;
    logic        g;
    logic        s;
    logic        up;
    logic [32:0] sum;
    // Defaults first, so no path leaves the shifted fields unassigned.
    ip         = 32'h00000000;
    g          = 1'b0;
    s          = 1'b0;
    up         = 1'b0;
    sgn        = operand[31];
    expo       = operand[30:23];
    frac       = operand[22:0];
    is_zero    = (expo == 8'h00) && (frac == 23'h000000);
    is_denorm  = (expo == 8'h00) && (frac != 23'h000000);
    is_nan     = (expo == vfc_pkg::EXP_MAX) && (frac != 23'h000000);
    is_inf     = (expo == vfc_pkg::EXP_MAX) && (frac == 23'h000000);
    frac_mode  = (mode == vfc_pkg::VFC_MODE_UFRAC);
    trunc_mode = (mode == vfc_pkg::VFC_MODE_SI_TRUNC) || (mode == vfc_pkg::VFC_MODE_UINT_TRUNC);
    eff        = {1'b0, expo} + (frac_mode ? vfc_pkg::FRAC_OFFSET : 9'h000);
    rsh        = vfc_pkg::INT_POINT - eff;
    wide       = {1'b1, frac, 64'h0} >> rsh[6:0];
    // Integer part with guard and sticky bits below it.
    if (eff >= vfc_pkg::INT_POINT) begin
      ip = {8'h00, 1'b1, frac} << eff[3:0] - vfc_pkg::INT_POINT[3:0];
      g  = 1'b0;
      s  = 1'b0;
    end else if (rsh >= vfc_pkg::SHIFT_LOST) begin
      ip = 32'h00000000;
      g  = 1'b0;
      s  = 1'b1;
    end else begin
      ip = {8'h00, wide[87:64]};
      g  = wide[63];
      s  = |wide[62:0];
    end
    // Rounding increment; truncating modes never round.
    case (rnd)
      vfc_pkg::VFC_RND_NEAREST: up = g & (s | ip[0]);
      vfc_pkg::VFC_RND_UP:      up = ~sgn & (g | s);
      vfc_pkg::VFC_RND_DOWN:    up = sgn & (g | s);
      default:                  up = 1'b0;
    endcase
    if (trunc_mode) begin
      up = 1'b0;
    end
    sum      = {1'b0, ip} + {32'h00000000, up};
    in_range = frac_mode ? (expo < vfc_pkg::EXP_UF_LIMIT) : (expo <= vfc_pkg::EXP_SI_LIMIT);
    res      = '0;
    // Special inputs always flag invalid, with guard and sticky left clear.
    res.invalid = is_denorm | is_nan | is_inf;
    if (mode == vfc_pkg::VFC_MODE_SI_TRUNC) begin
      if (is_denorm || is_zero || is_nan) begin
        res.value = 32'h00000000;
      end else if (expo < vfc_pkg::EXP_SI_LIMIT) begin
        res.value  = sgn ? 32'(-ip) : ip;
        res.guard  = g;
        res.sticky = s;
      end else if (expo == vfc_pkg::EXP_SI_LIMIT && sgn && frac == 23'h000000) begin
        res.value = vfc_pkg::SAT_NEG;
      end else begin
        res.value   = sgn ? vfc_pkg::SAT_NEG : vfc_pkg::SAT_POS;
        res.invalid = 1'b1;
      end
      res.trunc_value = res.value;
    end else begin
      if (is_denorm || is_zero || sgn || is_nan) begin
        res.value = 32'h00000000;
      end else if (in_range && !sum[32]) begin
        res.value  = sum[31:0];
        res.guard  = g;
        res.sticky = s;
      end else begin
        res.value   = vfc_pkg::SAT_UNS;
        res.invalid = 1'b1;
      end
      res.trunc_value = (res.guard | res.sticky) ? ip : res.value;
    end
  end

endmodule

/* File: verif/vfc_conv_monitor.sv */
// Concurrent checks on the ports of the two-lane converter.
module vfc_conv_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        exc_invalid,
  input wire logic        exc_round,
  input wire logic        conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // Start strobe: a completed command write with the start bit set.
  // -----------------------------------------------------------------
  wire logic start = psel && penable && pwrite && paddr == vfc_pkg::OFS_CMD
                     && pwdata[vfc_pkg::CMD_START_BIT];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_start_answer: assert property (start |-> ##2 (conv_done || exc_invalid))
    else $error("no answer two cycles after start");
  a_exc_exclusive: assert property (!(exc_invalid && exc_round))
    else $error("invalid and round exceptions together");
  a_inv_cause: assert property (exc_invalid |-> $past(start, 2))
    else $error("invalid exception without a start");
  a_round_cause: assert property (exc_round |-> $past(start, 2))
    else $error("round exception without a start");
  a_done_cause: assert property (conv_done |-> $past(start, 2))
    else $error("done pulse without a start");
  a_inv_single: assert property (exc_invalid |=> !exc_invalid)
    else $error("invalid exception longer than one cycle");
  a_cmd_reads_zero: assert property (psel && penable && !pwrite
    && paddr == vfc_pkg::OFS_CMD |-> prdata == 32'h0) else $error("command word read not zero");
  a_err_unmapped: assert property (psel && penable && paddr > vfc_pkg::OFS_STATUS
    |-> pslverr && pready) else $error("unmapped access not refused");
endmodule
bind vfc_conv vfc_conv_monitor i_vfc_conv_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .exc_invalid(exc_invalid), .exc_round(exc_round), .conv_done(conv_done));

/* File: verif/vfc_conv_tb.sv */
// Self-checking bench of the converter against a behavioural lane model.
module vfc_conv_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic go = 1'h0, wr = 1'h0, seen_inv, seen_rnd;
  logic [7:0] addr = 8'h0, exp_st = 8'h0;
  logic [31:0] wdata = 32'h0, exp_up = 32'h0, exp_lo = 32'h0;
  wire logic psel, penable, pwrite, pready, pslverr, err, ack;
  wire logic exc_invalid, exc_round, conv_done;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata, prdata, rdata;
  int num_errors = 0, checks = 0, cycles = 0, seed = 99893;
  logic [69:0] tbl [12] = '{{6'h00, 32'h406ccccd, 32'hc0200000},
    {6'h00, 32'h4f000000, 32'hcf000000}, {6'h00, 32'h00000001, 32'h7fc00000},
    {6'h00, 32'hcf000001, 32'h7f800000}, {6'h10, 32'h7fc00000, 32'h3fc00000},
    {6'h20, 32'h406ccccd, 32'h3f800000}, {6'h01, 32'h3f000000, 32'hbf000000},
    {6'h01, 32'h3f800000, 32'h00000000}, {6'h09, 32'h2fffffff, 32'h3e000001},
    {6'h02, 32'h4f800000, 32'h4f7fffff}, {6'h23, 32'h40200000, 32'hff800000},
    {6'h12, 32'h80000000, 32'h00400000}};
  vfc_issue_model i_vfc_issue_model (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr),
    .addr(addr), .wdata(wdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .rdata(rdata), .err(err), .ack(ack));
  vfc_conv i_vfc_conv (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exc_invalid(exc_invalid), .exc_round(exc_round),
    .conv_done(conv_done));
  // ---------------------------------------------------------------
  // Clock, pulse capture and hang guard.
  // ---------------------------------------------------------------
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (exc_invalid === 1'h1) seen_inv = 1'h1;
    if (exc_round === 1'h1) seen_rnd = 1'h1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer after a random idle gap; waits for the model's ack.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    repeat (1 + $unsigned($random(seed)) % 3) @(posedge pclk);
    go <= 1'h1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk iff ack);
    go <= 1'h0;
  endtask
  // ---------------------------------------------------------------
  // Lane model: mode c[1:0], rounding c[3:2]; magnitude kept in a longint.
  // ---------------------------------------------------------------
  function automatic vfc_pkg::vfc_lane_t ref_lane(logic [31:0] op, logic [1:0] md,
                                                   logic [1:0] rn);
    vfc_pkg::vfc_lane_t r;
    longint m, ip;
    int sh;
    logic s, g, st, inc, uns, nrm;
    r = '0;
    {g, st, nrm, ip} = '0;
    s = op[31];
    uns = md != 2'h0;
    m = {1'h1, op[22:0]};
    sh = int'(op[30:23]) - (md == 2'h1 ? 118 : 150);
    if (op[30:23] == 8'h0) r.invalid = op[22:0] != 23'h0;
    else if (op[30:23] == 8'hff) begin
      r.invalid = 1'h1;
      if (op[22:0] == 23'h0 && !(uns && s))
        r.value = uns ? 32'hffffffff : (s ? 32'h80000000 : 32'h7fffffff);
    end else if (uns && s) r.value = 32'h0;
    else if (!uns && op[30:23] >= 8'h9e) begin
      r.value = s ? 32'h80000000 : 32'h7fffffff;
      r.invalid = !(s && op[30:23] == 8'h9e && op[22:0] == 23'h0);
    end else if (md == 2'h1 ? op[30:23] >= 8'h7f : op[30:23] > 8'h9e) begin
      r.value = 32'hffffffff;
      r.invalid = 1'h1;
    end else begin
      nrm = 1'h1;
      if (sh >= 0) ip = m << sh;
      else if (sh < -25) st = 1'h1;
      else begin
        ip = m >> -sh;
        g = m[-sh-1];
        st = (m & ((64'h1 << (-sh-1)) - 1)) != 0;
      end
      case (rn)
        2'h0: inc = g & (st | ip[0]);
        2'h1: inc = 1'h0;
        2'h2: inc = !s & (g | st);
        default: inc = s & (g | st);
      endcase
      if (md == 2'h0 || md == 2'h3) inc = 1'h0;
      r.trunc_value = s ? 32'(-ip) : 32'(ip);
      r.value = s ? 32'(-(ip + inc)) : 32'(ip + inc);
      r.invalid = ip + inc > 64'hffffffff;
      if (r.invalid) r.value = 32'hffffffff;
      {r.guard, r.sticky} = r.invalid ? 2'h0 : {g, st};
    end
    if (!nrm) r.trunc_value = r.value;
    return r;
  endfunction
  // One conversion on both lanes, then destination and status compared.
  task automatic conv(logic [31:0] up, logic [31:0] lo, logic [5:0] c);
    vfc_pkg::vfc_lane_t h;
    vfc_pkg::vfc_lane_t l;
    logic inx, exi, exr;
    h = ref_lane(up, c[1:0], c[3:2]);
    l = ref_lane(lo, c[1:0], c[3:2]);
    inx = h.guard | h.sticky | l.guard | l.sticky;
    exi = (h.invalid | l.invalid) & c[4];
    exr = !exi & inx & c[5];
    apb(1'h1, vfc_pkg::OFS_SRC_UP, up);
    apb(1'h1, vfc_pkg::OFS_SRC_LO, lo);
    apb(1'h1, vfc_pkg::OFS_CTRL, {26'h0, c});
    seen_inv = 1'h0;
    seen_rnd = 1'h0;
    apb(1'h1, vfc_pkg::OFS_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    if (!exi) begin
      exp_up = exr ? h.trunc_value : h.value;
      exp_lo = exr ? l.trunc_value : l.value;
      exp_st[6] = exp_st[6] | inx;
    end
    exp_st[5:0] = {h.sticky, h.guard, l.sticky, l.guard, h.invalid, l.invalid};
    if (exi) exp_st[5:2] = 4'h0;
    apb(1'h0, vfc_pkg::OFS_DST_UP, 32'h0);
    chk("dst_up", exp_up, rdata);
    apb(1'h0, vfc_pkg::OFS_DST_LO, 32'h0);
    chk("dst_lo", exp_lo, rdata);
    apb(1'h0, vfc_pkg::OFS_STATUS, 32'h0);
    chk("status", {24'h0, exp_st}, rdata);
    chk("exc_invalid", {31'h0, exi}, {31'h0, seen_inv});
    chk("exc_round", {31'h0, exr}, {31'h0, seen_rnd});
  endtask
  function automatic logic [31:0] rop();
    logic [31:0] v;
    v = $random(seed);
    if (v[0]) v[30:23] = 8'h70 + {2'h0, v[6:1]};
    return v;
  endfunction
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] c;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    foreach (tbl[i]) begin
      apb(1'h0, 8'h08 + 8'(4 * (i % 5)), 32'h0);
      if (i < 5) chk("reset_read", 32'h0, rdata);
    end
    apb(1'h1, vfc_pkg::OFS_DST_UP, 32'hffffffff);
    apb(1'h0, vfc_pkg::OFS_DST_UP, 32'h0);
    chk("dst_read_only", 32'h0, rdata);
    apb(1'h0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rdata);
    foreach (tbl[i]) conv(tbl[i][63:32], tbl[i][31:0], tbl[i][69:64]);
    for (int r = 0; r < 4; r++) begin
      conv(32'h40200000, 32'h3fc00000, {2'h0, 2'(r), 2'h2});
      conv(32'h3eaaaaab, 32'h3f7fffff, {2'h0, 2'(r), 2'h1});
    end
    for (int i = 0; i < 40; i++) begin
      c = $random(seed);
      conv(rop(), rop(), c[5:0]);
    end
    apb(1'h1, vfc_pkg::OFS_STATUS, 32'h40);
    exp_st[6] = 1'h0;
    apb(1'h0, vfc_pkg::OFS_STATUS, 32'h0);
    chk("status_clear", {24'h0, exp_st}, rdata);
    stop_test();
  end
endmodule

/* File: verif/vfc_issue_model.sv */
// Bus master model of the core's issue logic feeding the converter.
module vfc_issue_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [31:0]      rdata,
  output logic             err,
  output logic             ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // Setup, then access held until pready; released lines carry junk.
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {psel, penable, pwrite, err, ack} <= 5'h0;
      paddr <= 8'h0;
      pwdata <= 32'h0;
      rdata <= 32'h0;
    end else if (psel && penable && pready) begin
      rdata <= prdata;
      err <= pslverr;
      ack <= 1'h1;
      {psel, penable} <= 2'h0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end else if (psel) begin
      penable <= 1'h1;
    end else begin
      ack <= 1'h0;
      if (go && !ack) begin
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule
